// file: design/fsk_modem_pkg.sv
`default_nettype none
package fsk_modem_pkg;

    // ------------------------------------------------------------
    // Timing base
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned MARK_HZ       = 1200;
    localparam int unsigned SPACE_HZ      = 2200;
    localparam int unsigned BAUD          = 1200;
    localparam int unsigned PHASE_W       = 32;

    // Phase steps of the accumulator, rounded down
    localparam logic [31:0] MARK_STEP  = 32'((64'(MARK_HZ) << PHASE_W) / 64'(CLK_HZ));
    localparam logic [31:0] SPACE_STEP = 32'((64'(SPACE_HZ) << PHASE_W) / 64'(CLK_HZ));

    // Half-period boundary between mark and space: 1 / (2 * 1700 Hz)
    localparam int unsigned SPLIT_HZ      = MARK_HZ + SPACE_HZ;
    localparam int unsigned SPLIT_CYC     = CLK_HZ / SPLIT_HZ;

    // Longest gap between carrier pulses
    localparam int unsigned CD_GAP_US     = 2500;
    localparam int unsigned CD_GAP_CYC    = (CLK_HZ / 1_000_000) * CD_GAP_US;
    localparam int unsigned CD_PULSES     = 4;
    localparam int unsigned CNT_W         = 17;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0]  CTRL_ADDR     = 5'h00;
    localparam logic [4:0]  STATUS_ADDR   = 5'h04;
    localparam logic [4:0]  IRQ_STAT_ADDR = 5'h08;
    localparam logic [4:0]  IRQ_MASK_ADDR = 5'h0C;
    localparam logic [0:0]  CTRL_RESET    = 1'h1;
    localparam int unsigned IRQ_W         = 3;
    localparam int unsigned IRQ_CD_RISE   = 0;
    localparam int unsigned IRQ_CD_FALL   = 1;
    localparam int unsigned IRQ_RX_EDGE   = 2;

    typedef enum logic [0:0] {CD_HUNT, CD_LOCK} cd_state_t;

endpackage
`default_nettype wire

// file: design/tone_oscillator.sv
`default_nettype none
module tone_oscillator
    import fsk_modem_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        enable_i,
    input  wire logic [31:0] step_i,
    output logic             wave_o
);

    typedef struct packed {
        logic [PHASE_W-1:0] phase;
    } nco_t;

    nco_t st_r;
    nco_t st_nxt;

    // ------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // no phase jump
        // Only the step changes on a tone switch, so phase stays continuous
        if (enable_i) begin
            st_nxt.phase = st_r.phase + step_i;
        end else begin
            st_nxt.phase = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign wave_o = st_r.phase[PHASE_W-1];

endmodule
`default_nettype wire

// file: design/fsk_modem_digital_core.sv
// Function
// - Reset input low holds all logic reset
// - Request-to-send low enables oscillator and transmit
// - Request-to-send high disables modulator, receive mode
// - Low data 2200 Hz, high 1200 Hz
// - Tone switches with continuous phase
// - Both paths run at 1200 baud; the core has no bit timing and BAUD is unused
// - Receive data high at 1200, low 2200
// - Receive data passes only with carrier detect
// - Carrier detect after four consecutive carrier pulses
// - Demodulator disabled below minimum amplitude
// - Bits recovered from comparator zero crossings
// - Receive edge jitter within 12 percent bit
// - Carrier detect only in receive, four pulses
// - Carrier detect drops on 2.5 ms gap
`default_nettype none
module fsk_modem_digital_core
    import fsk_modem_pkg::*;
#(
    parameter int unsigned GAP_CYC = CD_GAP_CYC
)(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        reset_n_in_i,
    input  wire logic        request_to_send_n_i,
    input  wire logic        tx_data_i,
    input  wire logic        rx_comparator_in_i,
    input  wire logic        carrier_level_i,
    output logic             tx_tone_out_o,
    output logic             tx_active_o,
    output logic             rx_data_o,
    output logic             carrier_detect_o,
    output logic             irq_o,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);

    typedef struct packed {
        logic               tone;
        logic               tx_act;
        logic               rxd;
        logic               cd;
        logic               irq;
        logic               ack;
        logic [31:0]        dat;
        logic               rx_en;
        logic [IRQ_W-1:0]   irq_stat;
        logic [IRQ_W-1:0]   irq_mask;
        logic               cmp_d;
        logic               lvl_d;
        logic [CNT_W-1:0]   half_cnt;
        logic               demod;
        logic [CNT_W-1:0]   gap_cnt;
        logic [2:0]         pulses;
        cd_state_t          cd_st;
    } core_t;

    core_t st_r;
    core_t st_nxt;
    logic  wave;
    logic  core_rst;
    logic  wb_req;
    logic  cmp_edge;
    logic  lvl_rise;
    logic  gap_over;

    logic             wr_en;
    logic             wr_ctrl;
    logic             wr_stat;
    logic             wr_mask;
    logic [IRQ_W-1:0] w1c_clr;
    logic [31:0]      rd_word;

    assign core_rst = rst_i | ~reset_n_in_i;

    // ------------------------------------------------------------
    // Modulator
    // ------------------------------------------------------------
    // steps from clock
    tone_oscillator u_osc (
        .clk_i    (clk_i),
        .rst_i    (core_rst),
        .ce_i     (ce_i),
        .enable_i (~request_to_send_n_i),
        .step_i   (tx_data_i ? MARK_STEP : SPACE_STEP),
        .wave_o   (wave)
    );

    assign wb_req   = wb_cyc_i & wb_stb_i & ~st_r.ack;
    assign cmp_edge = rx_comparator_in_i ^ st_r.cmp_d;
    assign lvl_rise = carrier_level_i & ~st_r.lvl_d;
    assign gap_over = st_r.gap_cnt >= CNT_W'(GAP_CYC - 1);

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    // Only byte lane 0 carries register bits
    assign wr_en = wb_req & wb_we_i & wb_sel_i[0];

    always_comb begin
        wr_ctrl = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        rd_word = 32'h0;
        if (wb_adr_i == CTRL_ADDR) begin
            wr_ctrl    = wr_en;
            rd_word[0] = st_r.rx_en;
        end else if (wb_adr_i == STATUS_ADDR) begin
            rd_word[3:0] = {st_r.tx_act, st_r.demod, st_r.rxd, st_r.cd};
        end else if (wb_adr_i == IRQ_STAT_ADDR) begin
            wr_stat            = wr_en;
            rd_word[IRQ_W-1:0] = st_r.irq_stat;
        end else if (wb_adr_i == IRQ_MASK_ADDR) begin
            wr_mask            = wr_en;
            rd_word[IRQ_W-1:0] = st_r.irq_mask;
        end
    end

    // Write one to clear, bit by bit
    for (genvar i = 0; i < IRQ_W; i++) begin : g_w1c
        assign w1c_clr[i] = wr_stat & wb_dat_i[i];
    end

    always_comb begin
        logic [IRQ_W-1:0] ev;
        logic             cd_n;
        logic             demod_n;
        ev      = '0;
        st_nxt  = st_r;
        cd_n    = st_r.cd;
        demod_n = st_r.demod;

        // --------------------------------------------------------
        // Transmit path
        // --------------------------------------------------------
        // transmit mode on request
        st_nxt.tx_act = ~request_to_send_n_i;
        st_nxt.tone   = ~request_to_send_n_i & wave;

        // --------------------------------------------------------
        // Demodulator
        // --------------------------------------------------------
        st_nxt.cmp_d = rx_comparator_in_i;
        if (cmp_edge) begin
            st_nxt.half_cnt = '0;
            // decision per half cycle bounds jitter
            demod_n = st_r.half_cnt >= CNT_W'(SPLIT_CYC);
        end else if (st_r.half_cnt != '1) begin
            st_nxt.half_cnt = st_r.half_cnt + 1'b1;
        end
        st_nxt.demod = demod_n;

        // --------------------------------------------------------
        // Carrier detect
        // --------------------------------------------------------
        st_nxt.lvl_d = carrier_level_i;
        // Saturate: a long silence must never wrap into a short gap
        if (lvl_rise) begin
            st_nxt.gap_cnt = '0;
        end else if (st_r.gap_cnt != '1) begin
            st_nxt.gap_cnt = st_r.gap_cnt + 1'b1;
        end
        if (request_to_send_n_i == 1'b0) begin
            st_nxt.cd_st  = CD_HUNT;
            st_nxt.pulses = '0;
            cd_n          = 1'b0;
        end else begin
            case (st_r.cd_st)
                CD_HUNT: begin
                    if (gap_over && !lvl_rise) begin
                        st_nxt.pulses = '0;
                    end else if (lvl_rise) begin
                        if (st_r.pulses == 3'(CD_PULSES - 1)) begin
                            st_nxt.cd_st  = CD_LOCK;
                            st_nxt.pulses = '0;
                            cd_n          = 1'b1;
                        end else begin
                            st_nxt.pulses = st_r.pulses + 1'b1;
                        end
                    end
                end
                CD_LOCK: begin
                    if (gap_over && !lvl_rise) begin
                        st_nxt.cd_st = CD_HUNT;
                        cd_n         = 1'b0;
                    end
                end
                default: begin
                    st_nxt.cd_st = CD_HUNT;
                    cd_n         = 1'b0;
                end
            endcase
        end
        st_nxt.cd = cd_n;

        st_nxt.rxd = (cd_n & st_r.rx_en) ? demod_n : 1'b1;

        // --------------------------------------------------------
        // Events
        // --------------------------------------------------------
        ev[IRQ_CD_RISE] = cd_n & ~st_r.cd;
        ev[IRQ_CD_FALL] = ~cd_n & st_r.cd;
        ev[IRQ_RX_EDGE] = st_nxt.rxd ^ st_r.rxd;

        // --------------------------------------------------------
        // Wishbone slave, one wait state, ack for one cycle
        // --------------------------------------------------------
        st_nxt.ack = wb_req;
        st_nxt.dat = '0;
        if (wr_ctrl) begin
            st_nxt.rx_en = wb_dat_i[0];
        end
        if (wr_mask) begin
            st_nxt.irq_mask = wb_dat_i[IRQ_W-1:0];
        end
        // A write without lane 0 answers like a read
        if (wb_req && !wr_en) begin
            st_nxt.dat = rd_word;
        end
        // Set after clear so a new event is never lost
        st_nxt.irq_stat = (st_r.irq_stat & ~w1c_clr) | ev;
        st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_mask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (core_rst) begin
            st_r       <= '0;
            st_r.rxd   <= 1'b1;
            st_r.demod <= 1'b1;
            st_r.rx_en <= CTRL_RESET;
            st_r.cd_st <= CD_HUNT;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign tx_tone_out_o    = st_r.tone;
    assign tx_active_o      = st_r.tx_act;
    assign rx_data_o        = st_r.rxd;
    assign carrier_detect_o = st_r.cd;
    assign irq_o            = st_r.irq;
    assign wb_dat_o         = st_r.dat;
    assign wb_ack_o         = st_r.ack;

endmodule
`default_nettype wire

// file: sim/fsk_modem_sva.sv
`default_nettype none
module fsk_modem_sva #(
    parameter int unsigned GAP_CYC = 50000
)(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        reset_n_in_i,
    input wire logic        request_to_send_n_i,
    input wire logic        carrier_level_i,
    input wire logic        tx_tone_out_o,
    input wire logic        tx_active_o,
    input wire logic        rx_data_o,
    input wire logic        carrier_detect_o,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        lvl_r;
    logic [31:0] gap_r;
    // Cycles since the last carrier pulse began
    always_ff @(posedge clk_i) begin
        lvl_r <= carrier_level_i;
        gap_r <= (rst_i || (carrier_level_i && !lvl_r)) ? 32'h0 : gap_r + 32'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_rst_idle;
        !reset_n_in_i |=> !tx_tone_out_o && !tx_active_o && !carrier_detect_o && rx_data_o;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("not idle in reset");
    property p_tx_on; ce_i && reset_n_in_i && !request_to_send_n_i |=> tx_active_o; endproperty
    a_tx_on: assert property (p_tx_on) else $error("transmit not on");
    property p_rx_mode;
        (ce_i && reset_n_in_i && request_to_send_n_i) [*2] |=> !tx_active_o && !tx_tone_out_o;
    endproperty
    a_rx_mode: assert property (p_rx_mode) else $error("tone in receive");
    property p_cd_rts; ce_i && !request_to_send_n_i |=> !carrier_detect_o; endproperty
    a_cd_rts: assert property (p_cd_rts) else $error("carrier in transmit");
    property p_gate; !carrier_detect_o && !$past(carrier_detect_o) |-> rx_data_o; endproperty
    a_gate: assert property (p_gate) else $error("data without carrier");
    property p_gap; carrier_detect_o |-> gap_r <= GAP_CYC + 2; endproperty
    a_gap: assert property (p_gap) else $error("carrier held past gap");
    property p_ack; ce_i && reset_n_in_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("no bus answer");
    property p_ack_one; ce_i && wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_dat_zero; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
    c_cd: cover property ($rose(carrier_detect_o));
    c_tx: cover property ($rose(tx_active_o));
    c_rd: cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule
`default_nettype wire

// file: sim/line_tone_source.sv
`default_nettype none
module line_tone_source
    import fsk_modem_pkg::*;
#(
    parameter int PULSE_CYC = 1000
)(
    input  wire logic clk_i,
    input  wire logic en_i,
    input  wire logic mark_i,
    output logic      cmp_o,
    output logic      lvl_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MH = CLK_HZ / (2 * MARK_HZ);
    localparam int SH = CLK_HZ / (2 * SPACE_HZ);
    int ph = 0;
    int pc = 0;
    initial cmp_o = 1'b0;
    initial lvl_o = 1'b0;
    always @(posedge clk_i) begin
        ph <= ph + 1;
        pc <= (pc + 1) % PULSE_CYC;
        lvl_o <= en_i && pc == 0;
        if (!en_i || ph + 1 >= (mark_i ? MH : SH)) begin
            cmp_o <= ~cmp_o;
            ph <= 0;
        end
    end
endmodule
`default_nettype wire

// file: sim/fsk_modem_digital_core_tb.sv
`default_nettype none
module fsk_modem_digital_core_tb;
    import fsk_modem_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int GAP = 2000;
    localparam int MH = CLK_HZ / (2 * MARK_HZ);
    localparam int SH = CLK_HZ / (2 * SPACE_HZ);
    logic        clk_i = 1'b0, rst_i = 1'b1, rst_n = 1'b1, rts_n = 1'b1, ce = 1'b1;
    logic        txd = 1'b1, src_en = 1'b0, mark = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        cmp, lvl, tone, tx_act, rxd, cd, irq, ack;
    logic [4:0]  adr = 5'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic [31:0] exp_q[$];
    int          err_count = 0, total_checks = 0;
    always #25 clk_i = ~clk_i;
    line_tone_source #(.PULSE_CYC(1000)) src (.clk_i(clk_i), .en_i(src_en), .mark_i(mark),
        .cmp_o(cmp), .lvl_o(lvl));
    fsk_modem_digital_core #(.GAP_CYC(GAP)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .reset_n_in_i(rst_n), .request_to_send_n_i(rts_n), .tx_data_i(txd),
        .rx_comparator_in_i(cmp), .carrier_level_i(lvl), .tx_tone_out_o(tone),
        .tx_active_o(tx_act), .rx_data_o(rxd), .carrier_detect_o(cd), .irq_o(irq),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack));
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic cmp_rd(input logic [31:0] got);
        if (exp_q.size() == 0) begin
            total_checks++;
            err_count++;
            $display("unexpected at %0t: got %0h exp %0h (no read pending)", $time, got, 32'h0);
        end else begin
            cmp_v(got, exp_q.pop_front());
        end
    endtask
    task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
        k = 0;
        while (s !== v && k < lim) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= lim) begin
            err_count++;
            wrap_up();
        end
    endtask
    task automatic tone_half(output int n);
        int k;
        wait_lvl(tone, ~tone, 20000, k);
        wait_lvl(tone, ~tone, 20000, n);
    endtask
    task automatic wb(input logic [4:0] a, input logic [31:0] d, input logic w);
        int n;
        n = 0;
        {adr, wdat, we, sel, cyc, stb} <= {a, d, w, 4'hF, 2'h3};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            wrap_up();
        end
        {cyc, stb} <= 2'h0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(a, 32'h0, 1'b0);
    endtask
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) cmp_rd(rdat);
    end
    initial begin
        #4_500_000;
        err_count++;
        wrap_up();
    end
    initial begin
        int m, k;
        m = $urandom(32'h58D9);
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        cmp_v({tone, tx_act, cd, rxd}, 4'h1);
        rd(CTRL_ADDR, 32'h1);
        rd(IRQ_MASK_ADDR, 32'h0);
        rd(5'h10, 32'h0);
        m = $urandom() & 7;
        wb(IRQ_MASK_ADDR, 32'(m), 1'b1);
        rd(IRQ_MASK_ADDR, 32'(m));
        wb(IRQ_MASK_ADDR, 32'h1, 1'b1);
        // Carrier present all through transmit
        {src_en, rts_n} <= 2'h2;
        repeat (2) @(posedge clk_i);
        cmp_v(tx_act, 1'b1);
        tone_half(k);
        cmp_v(32'(k >= MH - 2 && k <= MH + 2), 32'h1);
        txd <= 1'b0;
        tone_half(k);
        cmp_v(32'(k >= SH - 2 && k <= SH + 2), 32'h1);
        cmp_v(cd, 1'b0);
        rts_n <= 1'b1;
        repeat (2) @(posedge clk_i);
        cmp_v({tone, tx_act}, 2'h0);
        wait_lvl(cd, 1'b1, 6000, k);
        cmp_v(32'(k >= 2990), 32'h1);
        repeat (2) @(posedge clk_i);
        cmp_v(irq, 1'b1);
        wb(IRQ_STAT_ADDR, 32'h1, 1'b1);
        @(posedge clk_i);
        cmp_v(irq, 1'b0);
        // start bit space, stop bit mark
        mark <= 1'b0;
        wait_lvl(rxd, 1'b0, 20000, k);
        rd(STATUS_ADDR, 32'h1);
        mark <= 1'b1;
        wait_lvl(rxd, 1'b1, 20000, k);
        src_en <= 1'b0;
        wait_lvl(cd, 1'b0, GAP + 1200, k);
        cmp_v(32'(k >= GAP - 1000), 32'h1);
        repeat (3) @(posedge clk_i);
        cmp_v({rxd, irq}, 2'h2);
        src_en <= 1'b1;
        wait_lvl(cd, 1'b1, 6000, k);
        // Clock enable low freezes every output
        {ce, rts_n} <= 2'h0;
        repeat (3) @(posedge clk_i);
        cmp_v({tx_act, cd}, 2'h1);
        ce <= 1'b1;
        repeat (2) @(posedge clk_i);
        cmp_v(cd, 1'b0);
        rts_n <= 1'b1;
        wait_lvl(cd, 1'b1, 6000, k);
        cmp_v(32'(k >= 2990), 32'h1);
        wb(CTRL_ADDR, 32'h0, 1'b1);
        rst_n <= 1'b0;
        @(posedge clk_i);
        rst_n <= 1'b1;
        @(posedge clk_i);
        cmp_v({tone, tx_act, cd, rxd}, 4'h1);
        rd(CTRL_ADDR, 32'h1);
        wrap_up();
    end
endmodule
bind fsk_modem_digital_core fsk_modem_sva #(.GAP_CYC(GAP_CYC)) u_sva (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(ce_i), .reset_n_in_i(reset_n_in_i),
    .request_to_send_n_i(request_to_send_n_i), .carrier_level_i(carrier_level_i),
    .tx_tone_out_o(tx_tone_out_o), .tx_active_o(tx_active_o), .rx_data_o(rx_data_o),
    .carrier_detect_o(carrier_detect_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire
